// *** bench/pud_rt_model.sv ***
// routing unit stand-in that answers channel read requests
// assumes the channel clock and reset; delay is set by the bench
`timescale 1ns/1ps
`default_nettype none
module pud_rt_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [3:0] dly_i,
	input wire pud_pkg::pud_cmp_t data_i,
	output logic valid_o,
	output pud_pkg::pud_cmp_t data_o
);
	// ****************
	// request service
	// ****************
	logic [3:0] cnt_q;
	// valid pulse after dly_i waiting cycles, repeated every dly_i plus 2 cycles while req_i stays high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			valid_o <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			if (req_i && !valid_o) begin
				valid_o <= (cnt_q >= dly_i);
				cnt_q <= (cnt_q >= dly_i) ? 4'h0 : cnt_q + 4'h1;
			end
		end
	end
	// line shows the inverse outside the valid cycle
	assign data_o = valid_o ? data_i : ~data_i;
endmodule
`default_nettype wire

// *** bench/tb_pwm_updown_channel.sv ***
// self-checking bench for the pwm up-down channel
// assumes pud_rt_model as routing partner; capture trigger held low, chained trigger pulsed once
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_updown_channel;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} pud_row_t;
	logic clk_i, rst_i, tick_i, cyc, stb, we, ack, req, vld, pwm, irq, p, trg;
	logic [3:0] dly;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, r;
	logic [3:0] sel;
	pud_pkg::pud_cmp_t rtd;
	int errors, n_tests, n, k;
	int cnt [4];
	pud_row_t rows [10];
	pud_channel dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i),
		.chained_trigger_in_i(trg), .capture_trigger_in_i(1'b0), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rt_req_o(req), .rt_valid_i(vld), .rt_data_i(rtd),
		.pwm_o(pwm), .period_match_irq_o(), .duty_match_irq_o(), .irq_o(irq));
	pud_rt_model rt (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .dly_i(dly),
		.data_i({16'h0008, 16'h0003}), .valid_o(vld), .data_o(rtd));
	// ****************
	// tasks
	// ****************
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
		r = rdat;
		if (t >= 20) errors++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic ticks(input int t);
		tick_i <= 1'b1;
		repeat (t) @(posedge clk_i);
		tick_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] s,
		input logic lv, input logic rt);
		return {20'h00000, 3'h0, rt, 2'h0, lv, s, m, 1'b1};
	endfunction
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// clock generation
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// watchdog
	initial begin
		repeat (90000) @(posedge clk_i);
		errors++;
		end_sim;
	end
	// ****************
	// stimulus and checks
	// ****************
	initial begin
		{rst_i, tick_i, cyc, stb, we, adr, wdat, sel} = {3'h4, 2'h0, 8'h00, 32'h0, 4'hF};
		errors = 0;
		n_tests = 0;
		trg = 1'b0;
		dly = 4'h2;
		rows = '{'{1'b0, pud_pkg::OFS_CTRL, 32'h0}, '{1'b0, pud_pkg::OFS_PER, 32'hFFFF},
			'{1'b0, pud_pkg::OFS_DUTY, 32'h0}, '{1'b1, pud_pkg::OFS_SHPER, 32'h8},
			'{1'b0, pud_pkg::OFS_SHPER, 32'h8}, '{1'b1, pud_pkg::OFS_SHDUTY, 32'h3},
			'{1'b0, pud_pkg::OFS_SHDUTY, 32'h3}, '{1'b1, pud_pkg::OFS_IRQ_MASK, 32'h0},
			'{1'b1, 8'h40, 32'h5}, '{1'b0, 8'h40, 32'h0}};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("outputs", 32'h0, {29'h0, pwm, irq, req});
		// register rows, shadow values set over the config bus
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("reg", rows[i].d, r);
		end
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_UP, 1'b1, 1'b0));
		bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
		k = r[15:0];
		ticks(5);
		bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
		chk("cnt_adv", k + 5, r[15:0]);
		bus(1'b1, pud_pkg::OFS_CTRL, 32'h0);
		ticks(10);
		bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
		chk("cnt_hold", k + 5, r[15:0]);
		// run through one full wrap so the shadow values reach the work registers
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_UP, 1'b1, 1'b0));
		ticks(65545);
		bus(1'b0, pud_pkg::OFS_PER, 32'h0);
		chk("per_load", 32'h8, r);
		for (k = 0; k < 10; k++) begin
			ticks(1);
			bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
			chk("pwm_up", {31'h0, r[15:0] >= 16'h3}, {31'h0, pwm});
		end
		p = pwm;
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_UP, 1'b0, 1'b0));
		// one tick with no compare trigger: old level must still drive the output
		ticks(1);
		chk("level_up", {31'h0, p}, {31'h0, pwm});
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_UD, 1'b0, 1'b0));
		repeat (2) @(posedge clk_i);
		p = pwm;
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_UD, 1'b1, 1'b0));
		repeat (2) @(posedge clk_i);
		chk("level_ud", {31'h0, ~p}, {31'h0, pwm});
		// external direction trigger: no turn at period, turn on trigger, reload at zero
		bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
		k = r[15:0];
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, pud_pkg::SHAPE_DU, 1'b1, 1'b0) |
			(32'h1 << pud_pkg::POS_EXTDIR));
		ticks(20);
		trg <= 1'b1;
		ticks(1);
		trg <= 1'b0;
		bus(1'b0, pud_pkg::OFS_CNT, 32'h0);
		chk("ext_turn", 32'h10000 | (k + 19), r);
		ticks(30);
		// count routing requests for each up-down shape
		for (k = 1; k < 4; k++) begin
			bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_PWM, k[1:0], 1'b1, 1'b1));
			tick_i <= 1'b1;
			n = 0;
			p = req;
			repeat (300) begin
				@(posedge clk_i);
				if (req && !p) n++;
				p = req;
			end
			tick_i <= 1'b0;
			cnt[k] = n;
		end
		chk("req_du", 32'h1, {31'h0, cnt[1] > 8});
		chk("req_ud", 32'h1, {31'h0, cnt[2] > 8});
		chk("req_both", 32'h1, {31'h0, cnt[3] + 2 >= 2 * cnt[2] && cnt[3] <= 2 * cnt[2] + 2});
		// compare mode, non-blocking: pending read kept after service while disabled with hold
		dly <= 4'hF;
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_CMP, pud_pkg::SHAPE_UP, 1'b0, 1'b1));
		for (n = 0; n < 40 && !req; n++) ticks(1);
		bus(1'b1, pud_pkg::OFS_CTRL, ctl(pud_pkg::MODE_CMP, pud_pkg::SHAPE_UP, 1'b0, 1'b1) ^ 32'h401);
		repeat (40) @(posedge clk_i);
		chk("rt_keep", 32'h1, {31'h0, req});
		bus(1'b1, pud_pkg::OFS_CTRL, 32'h0);
		@(posedge clk_i);
		chk("rt_drop", 32'h0, {31'h0, req});
		dly <= 4'h2;
		// interrupt status, mask and clear
		bus(1'b0, pud_pkg::OFS_IRQ_STAT, 32'h0);
		chk("stat", 32'h3, {30'h0, r[1:0]});
		chk("irq_masked", 32'h0, {31'h0, irq});
		bus(1'b1, pud_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("irq_on", 32'h1, {31'h0, irq});
		bus(1'b1, pud_pkg::OFS_IRQ_STAT, 32'h3);
		bus(1'b0, pud_pkg::OFS_IRQ_STAT, 32'h0);
		chk("stat_clr", 32'h0, {30'h0, r[1:0]});
		chk("irq_off", 32'h0, {31'h0, irq});
		// reset in mid-run returns outputs and working period to defaults
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("rst_out", 32'h0, {29'h0, pwm, irq, req});
		bus(1'b0, pud_pkg::OFS_PER, 32'h0);
		chk("rst_per", {16'h0000, pud_pkg::PER_RESET}, r);
		end_sim;
	end
endmodule
`default_nettype wire

// *** design/pud_channel.sv ***
// pwm up-down channel with wishbone slave, routing read port and interrupt
// assumes tick_i is a one-cycle enable on clk_i; trigger inputs are same-domain pulses
`timescale 1ns/1ps
`default_nettype none
module pud_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic chained_trigger_in_i,
	input wire logic capture_trigger_in_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic rt_req_o,
	input wire logic rt_valid_i,
	input wire pud_pkg::pud_cmp_t rt_data_i,
	output logic pwm_o,
	output logic period_match_irq_o,
	output logic duty_match_irq_o,
	output logic irq_o
);
	localparam int W = pud_pkg::CNT_W;

	// ************************************************************
	// register bus
	// ************************************************************
	logic [11:0] ctrl_q;
	pud_pkg::pud_cmp_t shadow_q, work_q;
	logic [W-1:0] cnt_q;
	logic down_q, level_q, pwm_q, req_q, ack_q;
	logic [1:0] stat_q, mask_q;
	logic [1:0] ev_w;
	logic [31:0] rdata_w;

	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	wire en_w = ctrl_q[pud_pkg::POS_EN];
	wire [1:0] mode_w = ctrl_q[pud_pkg::POS_MODE +: 2];
	wire [1:0] shape_w = ctrl_q[pud_pkg::POS_SHAPE +: 2];
	wire sw_level = ctrl_q[pud_pkg::POS_LEVEL];
	wire extdir_w = ctrl_q[pud_pkg::POS_EXTDIR];
	wire trigsrc_w = ctrl_q[pud_pkg::POS_TRIGSRC];
	wire rten_w = ctrl_q[pud_pkg::POS_RTEN];
	wire block_w = ctrl_q[pud_pkg::POS_BLOCK];
	wire hold_w = ctrl_q[pud_pkg::POS_HOLD];
	wire srtrig_w = ctrl_q[pud_pkg::POS_SRTRIG];
	wire wr_ctrl = wb_wr & (wb_adr_i == pud_pkg::OFS_CTRL);
	wire wr_shper = wb_wr & (wb_adr_i == pud_pkg::OFS_SHPER);
	wire wr_shduty = wb_wr & (wb_adr_i == pud_pkg::OFS_SHDUTY);
	wire wr_stat = wb_wr & (wb_adr_i == pud_pkg::OFS_IRQ_STAT);
	wire wr_mask = wb_wr & (wb_adr_i == pud_pkg::OFS_IRQ_MASK);

	// read mux, unmapped reads as zero
	always_comb begin
		case (wb_adr_i)
			pud_pkg::OFS_CTRL: rdata_w = {20'h00000, ctrl_q};
			pud_pkg::OFS_SHPER: rdata_w = {16'h0000, shadow_q.period};
			pud_pkg::OFS_SHDUTY: rdata_w = {16'h0000, shadow_q.duty};
			pud_pkg::OFS_PER: rdata_w = {16'h0000, work_q.period};
			pud_pkg::OFS_DUTY: rdata_w = {16'h0000, work_q.duty};
			pud_pkg::OFS_CNT: rdata_w = {15'h0000, down_q, cnt_q};
			pud_pkg::OFS_IRQ_STAT: rdata_w = {30'h0, stat_q};
			pud_pkg::OFS_IRQ_MASK: rdata_w = {30'h0, mask_q};
			default: rdata_w = 32'h00000000;
		endcase
	end

	// one-wait-state ack, data registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack_q <= wb_req;
			wb_dat_o <= rdata_w;
		end
	end
	assign wb_ack_o = ack_q;

	// ************************************************************
	// counter and direction
	// ************************************************************
	wire updown_w = (shape_w != pud_pkg::SHAPE_UP); // nonzero shape: up-down
	wire trigger_source_select = trigsrc_w ? capture_trigger_in_i : chained_trigger_in_i;
	wire step = en_w & tick_i;
	wire at_top = (cnt_q == work_q.period - 16'h0001);
	wire turn_dn = step & updown_w & ~down_q & (extdir_w ? trigger_source_select : at_top);
	wire at_zero = (cnt_q == 16'h0001) & down_q;
	wire turn_up = step & updown_w & at_zero;
	wire up_wrap = step & ~updown_w & (cnt_q >= work_q.period);
	wire rl_ud = turn_dn & ~extdir_w & (shape_w[1]);
	// external direction reloads at zero only
	wire rl_du = turn_up & (shape_w[0] | extdir_w);
	wire reload = up_wrap | rl_ud | rl_du;
	// next count and direction, shared by counter and duty compare; up mode never counts down
	wire down_nx = updown_w & (turn_dn | (down_q & ~turn_up));
	wire [W-1:0] cnt_nx = ~step ? cnt_q :
		(up_wrap | turn_up) ? 16'h0000 :
		(turn_dn | (down_q & updown_w)) ? cnt_q - 16'h0001 : cnt_q + 16'h0001;

	// counter steps one per tick, holds when disabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 16'h0000;
			down_q <= 1'b0;
		end else if (step) begin
			cnt_q <= cnt_nx;
			down_q <= down_nx;
		end
	end

	// ************************************************************
	// shadow, working registers, routing reads
	// ************************************************************
	wire rt_take = req_q & rt_valid_i;
	wire pwm_mode = (mode_w == pud_pkg::MODE_PWM);
	// non-blocking compare mode keeps request while disabled with hold
	wire keep_req = (mode_w == pud_pkg::MODE_CMP) & rten_w & ~block_w & ~en_w & hold_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= pud_pkg::CTRL_RESET;
			shadow_q <= {pud_pkg::PER_RESET, pud_pkg::DUTY_RESET};
			work_q <= {pud_pkg::PER_RESET, pud_pkg::DUTY_RESET};
			req_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wb_dat_i[11:0];
			end
			if (rt_take) begin
				shadow_q <= rt_data_i;
			end else begin
				if (wr_shper) shadow_q.period <= wb_dat_i[W-1:0];
				if (wr_shduty) shadow_q.duty <= wb_dat_i[W-1:0];
			end
			if (reload) begin
				work_q <= shadow_q;
			end
			// new read after each reload, set wins over serve
			if (rten_w & reload) begin
				req_q <= 1'b1;
			end else if (rt_take & ~keep_req) begin
				req_q <= 1'b0;
			end else if (~rten_w) begin
				req_q <= 1'b0;
			end
		end
	end
	assign rt_req_o = req_q;

	// ************************************************************
	// output level and compare events
	// ************************************************************
	wire cmp_trig = step & ((cnt_q == work_q.duty) | up_wrap);
	// up-down uses written level at once; up mode waits for trigger
	wire eff_level = updown_w ? sw_level : level_q;
	// active from duty upwards, inactive once below duty going down
	wire duty_on = (cnt_nx >= work_q.duty);
	// pwm mode drives duty level; compare mode toggles on match
	wire pwm_d = pwm_mode ? (duty_on ? eff_level : ~eff_level) :
		((mode_w == pud_pkg::MODE_CMP) & cmp_trig ? ~pwm_q : pwm_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
			pwm_q <= 1'b0;
		end else begin
			// active level latched at compare trigger
			if (cmp_trig | ~en_w) level_q <= sw_level;
			if (step | (pwm_mode & updown_w)) pwm_q <= pwm_d;
		end
	end
	assign pwm_o = pwm_q;

	// match pulses in the same cycle as the output change, except duty match counting up in pwm mode, one tick after the output turns active
	// bit 1 duty match, bit 0 period match
	assign ev_w = {step & (cnt_q == work_q.duty) & (~srtrig_w | en_w), up_wrap | turn_dn};
	assign period_match_irq_o = ev_w[pud_pkg::IRQ_PER];
	assign duty_match_irq_o = ev_w[pud_pkg::IRQ_DUTY];

	// ************************************************************
	// interrupt status and mask
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= 2'h0;
			mask_q <= 2'h0;
		end else begin
			stat_q <= (stat_q & ~(wr_stat ? wb_dat_i[1:0] : 2'h0)) | ev_w;
			if (wr_mask) mask_q <= wb_dat_i[1:0];
		end
	end
	assign irq_o = |(stat_q & mask_q);

	// ************************************************************
	// assertions
	// ************************************************************
	property p_hold;
		@(posedge clk_i) disable iff (rst_i) !en_w |=> (cnt_q == $past(cnt_q));
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while disabled");
	property p_req;
		@(posedge clk_i) disable iff (rst_i) (rten_w && reload) |=> rt_req_o;
	endproperty
	a_req: assert property (p_req) else $error("no routing read after reload");
	property p_keep;
		@(posedge clk_i) disable iff (rst_i) (req_q && keep_req && !wr_ctrl) |=> rt_req_o;
	endproperty
	a_keep: assert property (p_keep) else $error("pending read dropped");
	property p_imm;
		@(posedge clk_i) disable iff (rst_i)
		(pwm_mode && updown_w && !wr_ctrl) |=>
		(pwm_o == ($past(duty_on) ? $past(sw_level) : !$past(sw_level)));
	endproperty
	a_imm: assert property (p_imm) else $error("level not immediate");
	property p_shape;
		@(posedge clk_i) disable iff (rst_i) (shape_w == pud_pkg::SHAPE_DU) |-> !rl_ud;
	endproperty
	a_shape: assert property (p_shape) else $error("reload at wrong turn");
	property p_ext;
		@(posedge clk_i) disable iff (rst_i) (extdir_w && updown_w && reload) |-> turn_up;
	endproperty
	a_ext: assert property (p_ext) else $error("reload not at zero");
	property p_irq;
		@(posedge clk_i) disable iff (rst_i) ev_w[0] |=> stat_q[0];
	endproperty
	a_irq: assert property (p_irq) else $error("period event lost");
	property p_up;
		@(posedge clk_i) disable iff (rst_i) (step && !updown_w) |=> !down_q;
	endproperty
	a_up: assert property (p_up) else $error("down count in up mode");
endmodule
`default_nettype wire

// *** design/pud_pkg.sv ***
// constants, field layouts and carrier types for the pwm up-down channel
// assumes a single clock domain; used by name, never imported
//
// What this block does
// - routing input in up-down pwm: new routing read after every shadow reload
// - shape 1 reloads at down-to-up, 2 at up-to-down, 3 at both turns
// - nonzero count shape gives up-down counting, zero gives continuous up counting
// - up-to-down turn at period minus one, or on selected external trigger
// - mode 2'b10 selects pwm output, 2'b01 selects compare output
// - duty phase level comes from active level bit, writable while running
// - up-count pwm: new active level applies at next compare trigger
// - up-down pwm: new active level applies immediately on write
// - compare mode non-blocking: pending routing read stays active when disabled holding
// - period match aligned with its output change; duty match too, except while counting up in pwm mode, where it comes one tick after the output turns active
// - external direction trigger: working registers reload only at counter zero
// - up: active when counter at or above duty; down: inactive below duty
package pud_pkg;
	localparam int unsigned CNT_W = 16;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SHPER = 8'h04;
	localparam logic [7:0] OFS_SHDUTY = 8'h08;
	localparam logic [7:0] OFS_PER = 8'h0C;
	localparam logic [7:0] OFS_DUTY = 8'h10;
	localparam logic [7:0] OFS_CNT = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	// control field positions
	localparam int unsigned POS_EN = 0;
	localparam int unsigned POS_MODE = 1;
	localparam int unsigned POS_SHAPE = 3;
	localparam int unsigned POS_LEVEL = 5;
	localparam int unsigned POS_EXTDIR = 6;
	localparam int unsigned POS_TRIGSRC = 7;
	localparam int unsigned POS_RTEN = 8;
	localparam int unsigned POS_BLOCK = 9;
	localparam int unsigned POS_HOLD = 10;
	localparam int unsigned POS_SRTRIG = 11;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [1:0] MODE_CMP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] SHAPE_UP = 2'h0;
	localparam logic [1:0] SHAPE_DU = 2'h1;
	localparam logic [1:0] SHAPE_UD = 2'h2;
	localparam logic [1:0] SHAPE_BOTH = 2'h3;
	localparam logic [15:0] PER_RESET = 16'hFFFF;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam int unsigned IRQ_PER = 0;
	localparam int unsigned IRQ_DUTY = 1;
	typedef struct packed {
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] duty;
	} pud_cmp_t;
endpackage
